// file: logic/lfc_pkg.sv
// Purpose: Shared constants for the luma frame capture block
// Assumes: 8-bit luma, 256x192 byte capture memory split into two frame areas
// Notes:   Register offsets index the plain software port
package lfc_pkg;
   localparam int          LUMA_W         = 8;
   localparam int          ADDR_W         = 16;
   localparam int          ROW_W          = 8;
   localparam int          COL_W          = 8;
   localparam logic [7:0]  FRAME_ROWS     = 8'h60;
   localparam logic [7:0]  LAST_COL       = 8'hFF;
   localparam logic [7:0]  FRAME_B_OFFSET = 8'h60;
   localparam logic [7:0]  HC_THRESHOLD   = 8'h78;
   localparam logic [7:0]  LUMA_WHITE     = 8'hFF;
   localparam logic [7:0]  LUMA_BLACK     = 8'h00;
   localparam logic [1:0]  PIX_DIV_LAST   = 2'h3;
   localparam logic [7:0]  DELAY_RESET    = 8'h04;
   localparam logic [1:0]  CTRL_RESET     = 2'h0;
   localparam int          CTRL_HC_BIT    = 0;
   localparam int          CTRL_FRZ_BIT   = 1;
   localparam logic [1:0]  OFF_CTRL       = 2'h0;
   localparam logic [1:0]  OFF_DELAY      = 2'h1;
   localparam logic [1:0]  OFF_STATUS     = 2'h2;
   localparam int          BUF_W          = 24;

   typedef enum logic [1:0]
   {
      CAP_IDLE   = 2'b00,
      CAP_WINDOW = 2'b01
   } lfc_cap_e;
endpackage

// file: logic/lfc_skid.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Ready towards the source is decoded from the registered fill level
`timescale 1ns/1ps
module lfc_skid
   import lfc_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   input  wire logic              i_valid,
   output logic                   o_ready,
   input  wire logic [BUF_W-1:0]  i_data,
   output logic                   o_valid,
   input  wire logic              i_ready,
   output logic [BUF_W-1:0]       o_data
);
   logic [BUF_W-1:0] mem_reg [2];
   logic             rd_ptr_reg;
   logic             wr_ptr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   assign o_ready = (count_reg != 2'h2);
   assign o_valid = (count_reg != 2'h0);
   assign o_data  = mem_reg[rd_ptr_reg];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         mem_reg[0] <= {BUF_W{1'b0}};
         mem_reg[1] <= {BUF_W{1'b0}};
      end
      else if (push)
      begin
         mem_reg[wr_ptr_reg] <= i_data;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
         begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   chk_no_overflow : assert property (@(posedge i_clk) disable iff (i_srst)
      count_reg == 2'h2 |-> !push)
      else $error("buffer pushed while full");
endmodule

// file: logic/lfc_capture.sv
// Purpose: Luma capture into a dual-frame 256x192 byte memory
// Assumes: Sync and valid inputs synchronous to I_CORE_CLK
// Notes:   Writes leave through a two-entry buffer; a sample arriving while it is full is dropped
//
// How it works
// - The write address is 16 bits, row in the upper byte and column in the lower byte.
// - The capture memory spans 256x192 byte locations shared by both frames.
// - The capture window opens on the frame indicator rising edge once the skip count elapses.
// - In a window exactly one of frame A or B is selected, alternating per window.
// - A write happens only in the window, with pixel valid high and frame indicator low.
// - Each frame area is 256x96, and frame B adds 96 to the row.
// - The spacing between A and B captures is adjustable, four frames after reset.
// - Vertical sync clears both row and column counters.
// - Horizontal sync clears the column counter and pixel divider, but not the row counter.
// - Each accepted sample advances the column, holding at column 255; no sample is taken once row 95 is done.
// - Only one pixel in four on a line and one line in two are stored.
// - High-contrast mode maps luma above 120 to 255 and 120 or below to 0.
// - With high contrast off the luma passes unchanged.
// - Freeze stops writes to frame B while frame A keeps updating.
// - Address, data, strobe and window flag are presented downstream.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module lfc_capture
   import lfc_pkg::*;
(
   input  wire logic                      I_CORE_CLK,
   input  wire logic                      I_SRST,
   input  wire logic [LUMA_W-1:0]         I_LUMA,
   input  wire logic                      I_PIXEL_VALID,
   input  wire logic                      I_HSYNC,
   input  wire logic                      I_VSYNC,
   input  wire logic                      I_FRAME,
   input  wire logic [1:0]                I_REG_ADDR,
   input  wire logic [7:0]                I_REG_WDATA,
   input  wire logic                      I_REG_WR,
   input  wire logic                      I_REG_RD,
   output logic      [7:0]                O_REG_RDATA,
   input  wire logic                      I_MEM_READY,
   output logic                           O_MEM_WE,
   output logic      [ADDR_W-1:0]         O_MEM_ADDR,
   output logic      [LUMA_W-1:0]         O_MEM_DATA,
   output logic                           O_CAPTURING,
   output logic                           O_SELECT_FRAME_A,
   output logic                           O_SELECT_FRAME_B
);
   import lfc_pkg::*;

   function automatic logic [LUMA_W-1:0] shape_luma(input logic [LUMA_W-1:0] y,
                                                    input logic hc);
      logic [LUMA_W-1:0] r;
      r = y;
      if (hc)
      begin
         r = (y > HC_THRESHOLD) ? LUMA_WHITE : LUMA_BLACK;
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   logic [1:0] ctrl_reg;
   logic [7:0] delay_reg;
   logic [7:0] rdata_reg;
   logic       src_ready;

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST)
      begin
         ctrl_reg  <= CTRL_RESET;
         delay_reg <= DELAY_RESET;
      end
      else if (I_REG_WR)
      begin
         if (I_REG_ADDR == OFF_CTRL)
         begin
            ctrl_reg <= I_REG_WDATA[1:0];
         end
         if (I_REG_ADDR == OFF_DELAY)
         begin
            delay_reg <= I_REG_WDATA;
         end
      end
   end

   lfc_cap_e state_reg;
   logic     sel_b_reg;
   logic     done_reg;

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST)
      begin
         rdata_reg <= 8'h00;
      end
      else if (I_REG_RD)
      begin
         case (I_REG_ADDR)
            OFF_CTRL:   rdata_reg <= {6'h00, ctrl_reg};
            OFF_DELAY:  rdata_reg <= delay_reg;
            OFF_STATUS: rdata_reg <= {4'h0, !src_ready, done_reg, sel_b_reg,
                                      state_reg == CAP_WINDOW};
            default:    rdata_reg <= 8'h00;
         endcase
      end
      else
      begin
         rdata_reg <= 8'h00;
      end
   end
   assign O_REG_RDATA = rdata_reg;

   // ----------------------------------------------------------------
   // Frame skip counter and capture window
   // ----------------------------------------------------------------
   logic       frame_d_reg;
   logic       frame_rise;
   logic [7:0] skip_reg;
   logic       open_now;
   logic       frozen_b;

   assign frame_rise = I_FRAME && !frame_d_reg;
   assign open_now   = frame_rise && (skip_reg + 8'h01 >= delay_reg);
   assign frozen_b   = ctrl_reg[CTRL_FRZ_BIT] && sel_b_reg;

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST)
      begin
         frame_d_reg <= 1'b1;
      end
      else
      begin
         frame_d_reg <= I_FRAME;
      end
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST)
      begin
         skip_reg  <= 8'h00;
         state_reg <= CAP_IDLE;
         sel_b_reg <= 1'b1;
      end
      else if (frame_rise)
      begin
         case (state_reg)
            CAP_IDLE:
            begin
               if (open_now)
               begin
                  state_reg <= CAP_WINDOW;
                  sel_b_reg <= ~sel_b_reg;
                  skip_reg  <= 8'h00;
               end
               else
               begin
                  skip_reg <= skip_reg + 8'h01;
               end
            end
            CAP_WINDOW:
            begin
               state_reg <= CAP_IDLE;
               skip_reg  <= 8'h01;
            end
            default: state_reg <= CAP_IDLE;
         endcase
      end
   end

   assign O_CAPTURING      = (state_reg == CAP_WINDOW);
   assign O_SELECT_FRAME_A = (state_reg == CAP_WINDOW) && !sel_b_reg;
   assign O_SELECT_FRAME_B = (state_reg == CAP_WINDOW) && sel_b_reg;

   // ----------------------------------------------------------------
   // Subsampling and address counters
   // ----------------------------------------------------------------
   logic [1:0]       pix_div_reg;
   logic             line_odd_reg;
   logic [ROW_W-1:0] row_reg;
   logic [COL_W-1:0] col_reg;
   logic             take;
   logic             hsync_d_reg;
   logic             line_seen_reg;

   assign take = (state_reg == CAP_WINDOW) && I_PIXEL_VALID && !I_FRAME
                 && !I_HSYNC && !I_VSYNC
                 && (pix_div_reg == 2'h0) && !line_odd_reg
                 && !done_reg && !frozen_b && src_ready;

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST)
      begin
         hsync_d_reg <= 1'b0;
      end
      else
      begin
         hsync_d_reg <= I_HSYNC;
      end
   end

   always_ff @(posedge I_CORE_CLK)
   begin
      if (I_SRST || I_VSYNC)
      begin
         row_reg      <= 8'h00;
         col_reg      <= 8'h00;
         pix_div_reg  <= 2'h0;
         line_odd_reg <= 1'b0;
         done_reg     <= 1'b0;
         line_seen_reg <= 1'b0;
      end
      else if (I_HSYNC)
      begin
         col_reg     <= 8'h00;
         pix_div_reg <= 2'h0;
         line_seen_reg <= 1'b0;
         if (!hsync_d_reg && line_seen_reg)
         begin
            line_odd_reg <= ~line_odd_reg;
            if (!line_odd_reg && !done_reg)
            begin
               if (row_reg == FRAME_ROWS - 8'h01)
               begin
                  done_reg <= 1'b1;
               end
               else
               begin
                  row_reg <= row_reg + 8'h01;
               end
            end
         end
      end
      else if (I_PIXEL_VALID && (state_reg == CAP_WINDOW) && !I_FRAME)
      begin
         pix_div_reg <= (pix_div_reg == PIX_DIV_LAST) ? 2'h0 : pix_div_reg + 2'h1;
         line_seen_reg <= 1'b1;
         if (take)
         begin
            if (col_reg == LAST_COL)
            begin
               col_reg <= LAST_COL;
            end
            else
            begin
               col_reg <= col_reg + 8'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Output buffer towards the memory owner
   // ----------------------------------------------------------------
   logic [BUF_W-1:0] buf_in;
   logic [BUF_W-1:0] buf_out;
   logic             buf_valid;
   logic [ROW_W-1:0] row_abs;

   assign row_abs = sel_b_reg ? row_reg + FRAME_B_OFFSET : row_reg;
   assign buf_in  = {row_abs, col_reg, shape_luma(I_LUMA, ctrl_reg[CTRL_HC_BIT])};

   lfc_skid u_skid
   (
      .i_clk   (I_CORE_CLK),
      .i_srst  (I_SRST),
      .i_valid (take),
      .o_ready (src_ready),
      .i_data  (buf_in),
      .o_valid (buf_valid),
      .i_ready (I_MEM_READY),
      .o_data  (buf_out)
   );

   assign O_MEM_WE   = buf_valid;
   assign O_MEM_ADDR = buf_out[BUF_W-1:LUMA_W];
   assign O_MEM_DATA = buf_out[LUMA_W-1:0];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_select_onehot : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      O_CAPTURING |-> (O_SELECT_FRAME_A ^ O_SELECT_FRAME_B))
      else $error("frame select not one-hot");
   chk_write_gate : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      take |-> O_CAPTURING && I_PIXEL_VALID && !I_FRAME)
      else $error("write outside window");
   chk_vsync_clear : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      I_VSYNC |=> (row_reg == 8'h00) && (col_reg == 8'h00))
      else $error("vsync did not clear counters");
   chk_hsync_col : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      I_HSYNC && !I_VSYNC |=> (col_reg == 8'h00) && (row_reg - $past(row_reg) <= 8'h01))
      else $error("hsync cleared row or kept column");
   chk_row_bound : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      row_reg < FRAME_ROWS)
      else $error("row past frame area");
   chk_b_offset : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      take && sel_b_reg |-> buf_in[BUF_W-1:LUMA_W+COL_W] == row_reg + FRAME_B_OFFSET)
      else $error("frame B row offset wrong");
   chk_contrast : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      ctrl_reg[CTRL_HC_BIT] |-> buf_in[7:0] == ((I_LUMA > 8'h78) ? 8'hFF : 8'h00))
      else $error("contrast mapping wrong");
   chk_passthru : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      !ctrl_reg[CTRL_HC_BIT] |-> buf_in[7:0] == I_LUMA)
      else $error("luma altered");
   chk_freeze_b : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      ctrl_reg[CTRL_FRZ_BIT] && O_SELECT_FRAME_B |-> !take)
      else $error("frame B written while frozen");
   chk_window_open : assert property (@(posedge I_CORE_CLK) disable iff (I_SRST)
      $rose(O_CAPTURING) |-> $past(frame_rise))
      else $error("window opened without frame edge");

   cov_window_a : cover property (@(posedge I_CORE_CLK) O_SELECT_FRAME_A && take);
   cov_window_b : cover property (@(posedge I_CORE_CLK) O_SELECT_FRAME_B && take);
   cov_stall    : cover property (@(posedge I_CORE_CLK) !src_ready && O_CAPTURING);
   cov_done     : cover property (@(posedge I_CORE_CLK) $rose(done_reg));
endmodule

// file: dv/lfc_video_src.sv
// Purpose: Video decoder model driving luma, pixel valid and syncs
// Assumes: Frames run back to back; luma is base + 16*line + pixel
// Notes:   Luma shows the inverse of its last value while not valid
`timescale 1ns/1ps
module lfc_video_src
#(
   parameter int PIX   = 16,
   parameter int LINES = 8,
   parameter int BLANK = 12
)
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_base,
   output logic [7:0]      o_luma,
   output logic            o_valid,
   output logic            o_hsync,
   output logic            o_vsync,
   output logic            o_frame
);
   initial
   begin
      o_luma  = 8'h00;
      o_valid = 1'b0;
      o_hsync = 1'b0;
      o_vsync = 1'b0;
      o_frame = 1'b0;
      forever
      begin
         @(posedge i_clk);
         o_frame <= 1'b1;
         o_vsync <= 1'b1;
         @(posedge i_clk);
         o_vsync <= 1'b0;
         repeat (BLANK) @(posedge i_clk);
         o_frame <= 1'b0;
         for (int l = 0; l < LINES; l++)
         begin
            for (int p = 0; p < PIX; p++)
            begin
               o_valid <= 1'b1;
               o_luma  <= i_base + 8'(16 * l + p);
               @(posedge i_clk);
               o_valid <= 1'b0;
               o_luma  <= ~o_luma;
               @(posedge i_clk);
            end
            o_hsync <= 1'b1;
            @(posedge i_clk);
            o_hsync <= 1'b0;
         end
      end
   end
endmodule

// file: dv/test_luma_frame_capture.sv
// Purpose: Self-checking bench for the luma frame capture block
// Assumes: 16 pixels by 8 lines per frame, so 16 words per window
// Notes:   Random ready, base luma and contrast; one frame stalled whole
`timescale 1ns/1ps
module test_luma_frame_capture;
   import lfc_pkg::*;
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rdy = 1'b0;
   logic [1:0] ra = 2'h0;
   logic [7:0] wd = 8'h00, base = 8'h00, xbase, luma, rdata;
   logic valid, hs, vs, fr, we, cap, sa, sb, fr_q, cap_q, exp_b, cur_b, cur_cap;
   logic [15:0] addr;
   logic [7:0] mdata;
   logic hc = 1'b0, frz = 1'b0, stall = 1'b0, c_hc, c_frz, c_st, seen, gchk;
   int seed = 32'h134A, failures = 0, tests_run = 0, words, gap, xgap = 4;
   always #25 clk = ~clk;
   lfc_video_src i_src (.i_clk(clk), .i_base(base), .o_luma(luma), .o_valid(valid),
      .o_hsync(hs), .o_vsync(vs), .o_frame(fr));
   lfc_capture i_dut (.I_CORE_CLK(clk), .I_SRST(srst), .I_LUMA(luma), .I_PIXEL_VALID(valid),
      .I_HSYNC(hs), .I_VSYNC(vs), .I_FRAME(fr), .I_REG_ADDR(ra), .I_REG_WDATA(wd),
      .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_MEM_READY(rdy), .O_MEM_WE(we),
      .O_MEM_ADDR(addr), .O_MEM_DATA(mdata), .O_CAPTURING(cap), .O_SELECT_FRAME_A(sa),
      .O_SELECT_FRAME_B(sb));
   // ---------------------------------------------
   // Checks and bus tasks
   // ---------------------------------------------
   function automatic logic [7:0] hcf(input logic [7:0] v, input logic h);
      return h ? ((v > HC_THRESHOLD) ? LUMA_WHITE : LUMA_BLACK) : v;
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] xp);
      tests_run++;
      if (got !== xp)
      begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, xp);
      end
   endtask
   task reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task reg_rd(input logic [1:0] a, input logic [7:0] xp, input logic [7:0] m);
      @(posedge clk);
      ra <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(16'(rdata & m), 16'(xp));
   endtask
   task test_done;
      $display("checks=%0d failures=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // Ready stalls and the write monitor
   // ---------------------------------------------
   always @(posedge clk)
      rdy <= stall ? 1'b0 : (($random(seed) & 3) != 0);
   always @(posedge clk)
   begin
      if (srst)
      begin
         fr_q = 1'b1;
         cap_q = 1'b0;
         exp_b = 1'b1;
         seen = 1'b0;
         gchk = 1'b0;
         gap = 0;
      end
      else
      begin
         if (fr && !fr_q)
         begin
            gap++;
            base <= $random(seed);
         end
         if (!fr && fr_q)
         begin
            if (seen && !c_st)
               chk(16'(words), (cur_cap && !(c_frz && cur_b)) ? 16'd16 : 16'd0);
            words = 0;
            cur_cap = cap;
            cur_b = sb;
            c_hc = hc;
            c_frz = frz;
            c_st = stall;
            xbase = base;
            seen = 1'b1;
         end
         if (cap && !cap_q)
         begin
            exp_b = !exp_b;
            chk({sa, sb}, {!exp_b, exp_b});
            if (gchk)
               chk(16'(gap), 16'(xgap));
            gap = 0;
            gchk = 1'b1;
         end
         if (we && rdy && !c_st)
         begin
            chk(addr, {8'(words / 4) + (cur_b ? FRAME_B_OFFSET : 8'h00), 8'(words % 4)});
            chk(16'(mdata), 16'(hcf(xbase + 8'(32 * (words / 4) + 4 * (words % 4)), c_hc)));
            words++;
         end
         fr_q = fr;
         cap_q = cap;
      end
   end
   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial
   begin
      #(40000 * 50);
      failures++;
      test_done;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      reg_rd(OFF_CTRL, {6'h00, CTRL_RESET}, 8'hFF);
      reg_rd(OFF_DELAY, DELAY_RESET, 8'hFF);
      reg_wr(2'h3, 8'hA5);
      reg_rd(2'h3, 8'h00, 8'hFF);
      repeat (10) @(posedge fr);
      @(posedge cap);
      repeat (2) @(negedge clk);
      reg_rd(OFF_STATUS, {6'h00, exp_b, 1'b1}, 8'h03);
      for (int m = 0; m < 3; m++)
      begin
         @(posedge fr);
         hc = (m == 1) ? 1'b0 : (m == 0 ? 1'b1 : 1'($random(seed)));
         frz = (m == 1);
         reg_wr(OFF_CTRL, {6'h00, frz, hc});
         if (m == 0)
         begin
            gchk = 1'b0;
            xgap = 2;
            reg_wr(OFF_DELAY, 8'h02);
         end
         repeat (6) @(posedge fr);
      end
      @(posedge cap);
      stall = 1'b1;
      repeat (120) @(posedge clk);
      reg_rd(OFF_STATUS, 8'h08, 8'h08);
      chk(16'(we), 16'h0001);
      @(posedge fr);
      stall = 1'b0;
      repeat (3) @(posedge fr);
      test_done;
   end
endmodule
